//--- shared/pifr_pkg.sv
// package: register map, field layout and state encodings of the second flag bank
package pifr_pkg;
  localparam int unsigned FLAG_W = 8;
  localparam logic [FLAG_W-1:0] FLAG_RESET = 8'h00;
  // flag bit positions
  localparam int unsigned BIT_CELL1 = 0;
  localparam int unsigned BIT_CELL2 = 1;
  localparam int unsigned BIT_CELL3 = 2;
  localparam int unsigned BIT_CELL4 = 3;
  localparam int unsigned BIT_T3_OVF = 4;
  localparam int unsigned BIT_T3_GATE = 5;
  localparam int unsigned BIT_CLK_SW = 6;
  localparam int unsigned BIT_OSC_FAIL = 7;
  // word offsets on the bus
  localparam logic [7:0] OFF_FLAGS = 8'h00;
  localparam logic [7:0] OFF_ENABLE = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_CLEAR = 8'h0C;
  localparam int unsigned ADDR_W = 8;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
  // bus data phase states, gray along idle -> write -> read path
  typedef enum logic [1:0] {
    PIFR_IDLE = 2'h0,
    PIFR_WRITE = 2'h1,
    PIFR_READ = 2'h3
  } pifr_phase_t;
endpackage

//--- verilog/pifr_flag.sv
`timescale 1ns/1ps
// one sticky flag bit: hardware set beats software clear
module pifr_flag (
  input wire logic hclk, // system clock
  input wire logic hresetn, // async reset, active low
  input wire logic set_evt, // hardware event pulse or level
  input wire logic sw_write, // software writes this bit
  input wire logic sw_value, // value written
  output logic flag // current flag
);
  logic flag_reg;
  logic flag_next;

  always_comb begin
    flag_next = flag_reg;
    if (sw_write) begin
      flag_next = sw_value;
    end
    // set wins over a clear in the same cycle
    if (set_evt) begin
      flag_next = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag = flag_reg;
endmodule

//--- verilog/pifr_edge.sv
`timescale 1ns/1ps
// rising or falling edge detector on a synchronous level
module pifr_edge #(
  parameter bit FALLING = 1'b0 // detect high-to-low when set
) (
  input wire logic hclk, // system clock
  input wire logic hresetn, // async reset, active low
  input wire logic level_in, // synchronous level
  output logic edge_pulse // one cycle per detected edge
);
  logic last_reg;
  logic last_next;

  always_comb begin
    last_next = level_in;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // start on the side that never fires, so a level held over reset is no edge
      last_reg <= ~FALLING;
    end else begin
      last_reg <= last_next;
    end
  end

  assign edge_pulse = FALLING ? (last_reg & ~level_in) : (~last_reg & level_in);
endmodule

//--- verilog/pifr_bank.sv
`timescale 1ns/1ps
// second peripheral interrupt request flag bank with AHB-Lite slave
module pifr_bank (
  input wire logic hclk, // system clock, 100 MHz
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready in
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  input wire logic osc_fail_evt, // clock monitor saw a failed oscillator
  input wire logic clock_switch_done_evt, // switch done, new oscillator ready
  input wire logic timer_three_gate, // timer-3 gate level, high while open
  input wire logic timer_three_overflow, // timer-3 overflow pulse
  input wire logic logic_cell4_output, // cell 4 interrupt condition met
  input wire logic logic_cell3_output, // cell 3 interrupt condition met
  input wire logic logic_cell2_output, // cell 2 interrupt condition met
  input wire logic logic_cell1_output, // cell 1 interrupt condition met
  output logic [7:0] irq_flags, // registered copy of the flag bank, one cycle behind
  output logic irq // level, any enabled flag set
);
  localparam int unsigned W = pifr_pkg::FLAG_W;

  pifr_pkg::pifr_phase_t phase_reg;
  pifr_pkg::pifr_phase_t phase_next;
  logic [pifr_pkg::ADDR_W-1:0] addr_reg;
  logic [pifr_pkg::ADDR_W-1:0] addr_next;
  logic [W-1:0] enable_reg;
  logic [W-1:0] enable_next;
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;
  logic irq_reg;
  logic irq_next;
  logic hreadyout_reg;
  logic hreadyout_next;
  logic hresp_reg;
  logic hresp_next;
  logic [W-1:0] flags_out_reg;
  logic [W-1:0] set_vec;
  logic [W-1:0] flags;
  logic [W-1:0] sw_write;
  logic [W-1:0] sw_value;
  logic gate_closed;
  logic access;

  assign access = hsel & hready &
    ((htrans == pifr_pkg::HTRANS_NONSEQ) | (htrans == pifr_pkg::HTRANS_SEQ));

  // gate closing is the falling edge of the gate level
  pifr_edge #(
    .FALLING(1'b1)
  ) u_gate_edge (
    .hclk(hclk),
    .hresetn(hresetn),
    .level_in(timer_three_gate),
    .edge_pulse(gate_closed)
  );

  // events feed the flags whatever the enable register holds
  always_comb begin
    set_vec = '0;
    set_vec[pifr_pkg::BIT_OSC_FAIL] = osc_fail_evt;
    set_vec[pifr_pkg::BIT_CLK_SW] = clock_switch_done_evt;
    set_vec[pifr_pkg::BIT_T3_GATE] = gate_closed;
    set_vec[pifr_pkg::BIT_T3_OVF] = timer_three_overflow;
    set_vec[pifr_pkg::BIT_CELL4] = logic_cell4_output;
    set_vec[pifr_pkg::BIT_CELL3] = logic_cell3_output;
    set_vec[pifr_pkg::BIT_CELL2] = logic_cell2_output;
    set_vec[pifr_pkg::BIT_CELL1] = logic_cell1_output;
  end

  // software writes land on the data phase of the flag or clear word
  always_comb begin
    sw_write = '0;
    sw_value = hwdata[W-1:0];
    if (phase_reg == pifr_pkg::PIFR_WRITE) begin
      if (addr_reg == pifr_pkg::OFF_FLAGS) begin
        sw_write = '1;
      end else if (addr_reg == pifr_pkg::OFF_CLEAR) begin
        // write-one-to-clear, zeros leave the bit alone
        sw_write = hwdata[W-1:0];
        sw_value = '0;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_flag
      pifr_flag u_flag (
        .hclk(hclk),
        .hresetn(hresetn),
        .set_evt(set_vec[g]),
        .sw_write(sw_write[g]),
        .sw_value(sw_value[g]),
        .flag(flags[g])
      );
    end
  endgenerate

  always_comb begin
    phase_next = pifr_pkg::PIFR_IDLE;
    addr_next = addr_reg;
    if (access) begin
      phase_next = hwrite ? pifr_pkg::PIFR_WRITE : pifr_pkg::PIFR_READ;
      addr_next = haddr[pifr_pkg::ADDR_W-1:0];
    end
  end

  always_comb begin
    enable_next = enable_reg;
    hrdata_next = pifr_pkg::RDATA_ZERO;
    // no wait states and no error responses
    hreadyout_next = 1'b1;
    hresp_next = 1'b0;
    case (phase_reg)
      pifr_pkg::PIFR_WRITE: begin
        if (addr_reg == pifr_pkg::OFF_ENABLE) begin
          enable_next = hwdata[W-1:0];
        end
      end
      default: begin
      end
    endcase
    // read data is registered in the address phase, valid next cycle
    if (access && !hwrite) begin
      case (haddr[pifr_pkg::ADDR_W-1:0])
        pifr_pkg::OFF_FLAGS: hrdata_next = {24'h000000, flags};
        pifr_pkg::OFF_STATUS: hrdata_next = {24'h000000, flags};
        pifr_pkg::OFF_ENABLE: hrdata_next = {24'h000000, enable_reg};
        default: hrdata_next = pifr_pkg::RDATA_ZERO;
      endcase
    end
    // enables only gate the output line, never the flags
    irq_next = |(flags & enable_reg);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_reg <= pifr_pkg::PIFR_IDLE;
      addr_reg <= '0;
      enable_reg <= pifr_pkg::FLAG_RESET;
      hrdata_reg <= pifr_pkg::RDATA_ZERO;
      irq_reg <= 1'b0;
      flags_out_reg <= pifr_pkg::FLAG_RESET;
      hreadyout_reg <= 1'b1;
      hresp_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      addr_reg <= addr_next;
      enable_reg <= enable_next;
      hrdata_reg <= hrdata_next;
      irq_reg <= irq_next;
      flags_out_reg <= flags;
      hreadyout_reg <= hreadyout_next;
      hresp_reg <= hresp_next;
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp = hresp_reg;
  assign irq = irq_reg;
  assign irq_flags = flags_out_reg;
endmodule

//--- tb/pifr_monitor.sv
// checker: port-level properties of the flag bank
`timescale 1ns/1ps
module pifr_monitor (
  input wire logic hclk, // system clock
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic osc_fail_evt, // oscillator failure event
  input wire logic clock_switch_done_evt, // switch done event
  input wire logic timer_three_gate, // gate level
  input wire logic timer_three_overflow, // overflow event
  input wire logic logic_cell4_output, // cell 4 event
  input wire logic logic_cell3_output, // cell 3 event
  input wire logic logic_cell2_output, // cell 2 event
  input wire logic logic_cell1_output, // cell 1 event
  input wire logic [7:0] irq_flags, // flag bank copy
  input wire logic irq // interrupt line
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_osc; osc_fail_evt |-> ##2 irq_flags[7]; endproperty
  a_osc: assert property (p_osc) else $error("osc flag late");
  property p_csw; clock_switch_done_evt |-> ##2 irq_flags[6]; endproperty
  a_csw: assert property (p_csw) else $error("switch flag late");
  // detector adds no register stage, window allows one cycle more
  property p_gate; $fell(timer_three_gate) |-> ##[2:3] irq_flags[5]; endproperty
  a_gate: assert property (p_gate) else $error("gate flag late");
  property p_ovf; timer_three_overflow |-> ##2 irq_flags[4]; endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag late");
  property p_c4; logic_cell4_output |-> ##2 irq_flags[3]; endproperty
  a_c4: assert property (p_c4) else $error("cell4 flag late");
  property p_c3; logic_cell3_output |-> ##2 irq_flags[2]; endproperty
  a_c3: assert property (p_c3) else $error("cell3 flag late");
  property p_c2; logic_cell2_output |-> ##2 irq_flags[1]; endproperty
  a_c2: assert property (p_c2) else $error("cell2 flag late");
  property p_c1; logic_cell1_output |-> ##2 irq_flags[0]; endproperty
  a_c1: assert property (p_c1) else $error("cell1 flag late");
  property p_hold; |($past(irq_flags) & ~irq_flags) |-> $past(hsel & hwrite & htrans[1], 3);
  endproperty
  a_hold: assert property (p_hold) else $error("flag fell without write");
  property p_irq; irq |-> |irq_flags; endproperty
  a_irq: assert property (p_irq) else $error("irq without flag");
endmodule
bind pifr_bank pifr_monitor u_mon (
  .hclk(hclk),
  .hresetn(hresetn),
  .hsel(hsel),
  .htrans(htrans),
  .hwrite(hwrite),
  .osc_fail_evt(osc_fail_evt),
  .clock_switch_done_evt(clock_switch_done_evt),
  .timer_three_gate(timer_three_gate),
  .timer_three_overflow(timer_three_overflow),
  .logic_cell4_output(logic_cell4_output),
  .logic_cell3_output(logic_cell3_output),
  .logic_cell2_output(logic_cell2_output),
  .logic_cell1_output(logic_cell1_output),
  .irq_flags(irq_flags),
  .irq(irq)
);

//--- tb/pifr_src_model.sv
// event sources: events mirror fire one cycle later, gate low while fire[5] is high
`timescale 1ns/1ps
module pifr_src_model (
  input wire logic hclk, // system clock
  input wire logic [7:0] fire, // event request per bit
  output logic [7:0] evt // bit 5 is the gate level
);
  always @(posedge hclk) evt <= {fire[7:6], ~fire[5], fire[4:0]};
endmodule

//--- tb/testbench.sv
// testbench: bus scoreboard for the flag bank
`timescale 1ns/1ps
module testbench;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp, irq, dp = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [31:0] q[$];
  logic [1:0] htrans = 0;
  logic [7:0] fire = 0, evt, irq_flags, m = 0, en, c;
  int mismatches = 0, n_compared = 0;
  always #5 hclk = ~hclk;
  pifr_src_model SRC (.hclk(hclk), .fire(fire), .evt(evt));
  pifr_bank DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .osc_fail_evt(evt[7]), .clock_switch_done_evt(evt[6]),
    .timer_three_gate(evt[5]), .timer_three_overflow(evt[4]), .logic_cell4_output(evt[3]),
    .logic_cell3_output(evt[2]), .logic_cell2_output(evt[1]), .logic_cell1_output(evt[0]),
    .irq_flags(irq_flags), .irq(irq));
  task automatic check(string n, logic [31:0] e, logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  always @(posedge hclk) begin
    if (dp) begin
      check("hrdata", q.pop_front(), hrdata);
      check("hresp", 0, hresp);
    end
    dp <= hsel & htrans[1] & !hwrite & hreadyout;
  end
  task automatic bus(logic [7:0] a, logic w, logic [31:0] d, logic [7:0] f);
    hsel <= 1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= w; fire <= f;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 0; htrans <= 2'h0; hwdata <= d; fire <= 8'h00;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    q.push_back(e);
    bus(a, 0, 32'h0, 8'h00);
  endtask
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    complete_run;
  end
  initial begin
    void'($urandom(32'h0D56));
    repeat (16) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    for (int i = 0; i < 5; i++) rd(8'(4 * i), 32'h0);
    for (int b = 0; b < 8; b++) begin
      fire <= 8'h01 << b;
      @(posedge hclk);
      fire <= 8'h00;
      repeat (5) @(posedge hclk);
      m[b] = 1'b1;
      rd(pifr_pkg::OFF_STATUS, {24'h0, m});
      check("irq_flags", m, irq_flags);
      check("irq", 0, irq);
    end
    rd(pifr_pkg::OFF_CLEAR, 32'h0);
    en = 8'($urandom) | 8'h01;
    bus(pifr_pkg::OFF_ENABLE, 1, {24'h0, en}, 8'h00);
    repeat (3) @(posedge hclk);
    check("irq", 1, irq);
    rd(pifr_pkg::OFF_ENABLE, {24'h0, en});
    c = 8'($urandom);
    bus(pifr_pkg::OFF_CLEAR, 1, {24'h0, c}, 8'h00);
    m = m & ~c;
    repeat (3) @(posedge hclk);
    check("irq", |(m & en), irq);
    rd(pifr_pkg::OFF_FLAGS, {24'h0, m});
    // overflow event lands on the clearing edge
    bus(pifr_pkg::OFF_FLAGS, 1, 32'h0, 8'h10);
    m = 8'h10;
    repeat (3) @(posedge hclk);
    rd(pifr_pkg::OFF_FLAGS, {24'h0, m});
    check("irq", |(m & en), irq);
    // a write of zero elsewhere must leave the flag standing
    bus(pifr_pkg::OFF_STATUS, 1, 32'h0, 8'h00);
    rd(pifr_pkg::OFF_FLAGS, {24'h0, m});
    // gate held closed across reset release must not count as a closing
    hresetn <= 0;
    fire <= 8'h20;
    repeat (2) @(posedge hclk);
    check("irq_flags", 0, irq_flags);
    hresetn <= 1;
    @(posedge hclk);
    rd(pifr_pkg::OFF_FLAGS, 32'h0);
    complete_run;
  end
endmodule
